// ==== logic/sadc_axil.sv ====
`timescale 1ns/10ps
module sadc_axil import sadc_pkg::*; (
  input  wire logic              clock,         // System clock
  input  wire logic              resetn,        // Async reset, active low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic [2:0]        s_axi_awprot,  // Unused
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Byte enables
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic [2:0]        s_axi_arprot,  // Unused
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  input  wire logic [31:0]       status_word,   // Live status
  input  wire logic [31:0]       result_word,   // Output register
  output logic [11:0]            analog_reg     // Analog input level
);
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic [31:0]       rd_mux;
  logic              rd_hit;
  logic              wr_go;
  logic              wr_hit;

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_hit = aw_addr_reg == REG_ANALOG;
  assign rd_hit = s_axi_araddr == REG_ANALOG || s_axi_araddr == REG_STATUS
               || s_axi_araddr == REG_RESULT;
  assign rd_mux = s_axi_araddr == REG_ANALOG ? {20'h00000, analog_reg} :
                  s_axi_araddr == REG_STATUS ? status_word :
                  s_axi_araddr == REG_RESULT ? result_word : 32'h00000000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      analog_reg   <= 12'h000;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (wr_hit && w_strb_reg[0])
          analog_reg[7:0] <= w_data_reg[7:0];
        if (wr_hit && w_strb_reg[1])
          analog_reg[11:8] <= w_data_reg[11:8];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== logic/sadc_pkg.sv ====
package sadc_pkg;
  // Clock and timing
  localparam int CLK_MHZ      = 100;
  localparam int CS_SETUP_NS  = 100;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int INT_CLK_NS   = 250;
  localparam int INT_DIV_CYC  = INT_CLK_NS * CLK_MHZ / 1000;
  localparam int CONV_NS      = 10000;
  localparam int CONV_TICKS   = CONV_NS / INT_CLK_NS;

  // Control word layout
  localparam int ADDR_MSB  = 7;
  localparam int ADDR_LSB  = 4;
  localparam int ORDER_BIT = 1;
  localparam int SIGN_BIT  = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Channel address codes and test levels
  localparam logic [3:0]  ADDR_LAST_AIN = 4'hA;
  localparam logic [3:0]  ADDR_TEST_MID = 4'hB;
  localparam logic [3:0]  ADDR_TEST_LO  = 4'hC;
  localparam logic [3:0]  ADDR_TEST_HI  = 4'hD;
  localparam logic [3:0]  ADDR_PWRDN    = 4'hE;
  localparam logic [11:0] LVL_MID       = 12'h800;
  localparam logic [11:0] LVL_LO        = 12'h000;
  localparam logic [11:0] LVL_HI        = 12'hFFF;
  localparam logic [11:0] SIGN_FLIP     = 12'h800;

  // Length codes and edge counts
  localparam logic [1:0] LCODE_8     = 2'h1;
  localparam logic [1:0] LCODE_16    = 2'h3;
  localparam logic [4:0] LEN_8       = 5'h08;
  localparam logic [4:0] LEN_12      = 5'h0C;
  localparam logic [4:0] LEN_16      = 5'h10;
  localparam logic [4:0] SAMPLE_EDGE = 5'h04;
  localparam logic [3:0] CTRL_BITS   = 4'h8;
  localparam logic [3:0] LEN_EDGE    = 4'h5;

  // Register map (byte addresses) and bus answers
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] REG_ANALOG  = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_RESULT  = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_SETUP = 4'b0010,
    S_SHIFT = 4'b0100,
    S_CONV  = 4'b1000
  } sadc_state_t;
endpackage

// ==== logic/sadc_seq.sv ====
// Behaviour
// - Select high: ignore inputs, output high impedance
// - Select falling edge starts a new sequence
// - Control word: address, length, order, polarity
// - Control bits taken on first eight rises
// - I/O cycle is 8, 12 or 16 clocks
// - Previous result shifts out during control load
// - Select held low: first bit at EOC rise
// - Select toggled: first bit at select fall
// - Later bits change on each falling clock
// - Sample from fourth fall, hold at last
// - Last fall drops EOC, launches conversion
// - EOC rises on the same clock the result latches
// - Conversion after I/O cycle, internal clock paced
// - Reset: EOC high, control register zero
// - Select high then low restarts cycle
// - Result shifts out in following I/O cycle
// - Conversion starts right after final fall
// - Setup wait after select falls
// - Length code 01=8, 11=16, else 12
// - 16-bit pads four zeros, 8-bit truncates
// - Address picks input, test level, power-down
// - Order bit LSB first, polarity bit bipolar
`timescale 1ns/10ps
module sadc_seq import sadc_pkg::*; #(
  parameter int SETUP_CYC  = CS_SETUP_CYC,
  parameter int INT_DIV    = INT_DIV_CYC,
  parameter int CONV_COUNT = CONV_TICKS
) (
  input  wire logic              clock,         // System clock, 100 MHz
  input  wire logic              resetn,        // Async reset, active low
  input  wire logic              cs_n,          // Select pin, active low
  input  wire logic              io_clk,        // Shift clock pin
  input  wire logic              data_in,       // Serial control input
  output logic                   data_out,      // Serial result output
  output logic                   data_out_oe_n, // Output enable, active low
  output logic                   eoc,           // End of conversion
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic [2:0]        s_axi_awprot,  // Unused
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Byte enables
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic [2:0]        s_axi_arprot,  // Unused
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready   // Read data ready
);
  if (SETUP_CYC < 1 || SETUP_CYC > 255 || INT_DIV < 1 || INT_DIV > 255
      || CONV_COUNT < 1 || CONV_COUNT > 255) begin : g_chk
    $error("sadc_seq: timing parameter out of range 1..255");
  end

  localparam logic [7:0] SETUP_LAST = 8'(SETUP_CYC - 1);
  localparam logic [7:0] DIV_LAST   = 8'(INT_DIV - 1);
  localparam logic [7:0] CONV_LAST  = 8'(CONV_COUNT - 1);

  sadc_state_t state_reg;
  sadc_state_t state_next;
  logic [2:0]  pins_s;
  logic        cs_n_s;
  logic        io_clk_s;
  logic        din_s;
  logic        cs_d_reg;
  logic        io_clk_d_reg;
  logic [7:0]  setup_cnt_reg;
  logic [4:0]  fcnt_reg;
  logic [3:0]  rcnt_reg;
  logic [6:0]  sh_reg;
  logic [7:0]  ctrl_reg;
  logic [4:0]  len_reg;
  logic        sampling_reg;
  logic [11:0] hold_reg;
  logic        pwrdn_reg;
  logic [7:0]  launch_ctrl_reg;
  logic        busy_reg;
  logic [7:0]  div_cnt_reg;
  logic [7:0]  tick_cnt_reg;
  logic [15:0] img_reg;
  logic [15:0] out_sh_reg;
  logic        dout_reg;
  logic        eoc_reg;
  logic [11:0] analog_reg;

  // Select idles high through reset
  sadc_sync #(.W(3), .RST_VAL(3'h4)) u_pin_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      ({cs_n, io_clk, data_in}),
    .q      (pins_s)
  );

  assign cs_n_s   = pins_s[2];
  assign io_clk_s = pins_s[1];
  assign din_s    = pins_s[0];

  // Edge detection on synchronised pins
  logic cs_fall;
  logic rise_ev;
  logic fall_ev;
  assign cs_fall = cs_d_reg && !cs_n_s;
  assign rise_ev = io_clk_s && !io_clk_d_reg;
  assign fall_ev = !io_clk_s && io_clk_d_reg;

  // Edges only count inside the shift phase
  logic shift_rise;
  logic shift_fall;
  logic last_fall;
  logic ctrl_take;
  logic ctrl_done;
  logic len_take;
  logic seq_start;
  logic [4:0] fcnt_inc;
  assign shift_rise = state_reg == S_SHIFT && rise_ev;
  assign shift_fall = state_reg == S_SHIFT && fall_ev;
  assign fcnt_inc   = fcnt_reg + 5'h01;
  assign last_fall  = shift_fall && fcnt_inc == len_reg;
  assign ctrl_take  = shift_rise && rcnt_reg < CTRL_BITS;
  assign ctrl_done  = shift_rise && rcnt_reg == CTRL_BITS - 4'h1;
  assign len_take   = shift_rise && rcnt_reg == LEN_EDGE;
  assign seq_start  = state_reg != S_SHIFT && state_next == S_SHIFT;

  logic [1:0] len_code;
  logic [4:0] len_dec;
  assign len_code = {sh_reg[0], din_s};
  assign len_dec  = len_code == LCODE_8  ? LEN_8 :
                    len_code == LCODE_16 ? LEN_16 : LEN_12;

  logic [3:0]  addr_sel;
  logic [11:0] sel_level;
  assign addr_sel  = ctrl_reg[ADDR_MSB:ADDR_LSB];
  assign sel_level = addr_sel <= ADDR_LAST_AIN ? analog_reg :
                     addr_sel == ADDR_TEST_MID ? LVL_MID :
                     addr_sel == ADDR_TEST_LO  ? LVL_LO :
                     addr_sel == ADDR_TEST_HI  ? LVL_HI : 12'h000;

  logic int_tick;
  logic conv_done;
  assign int_tick  = busy_reg && div_cnt_reg == DIV_LAST;
  assign conv_done = int_tick && tick_cnt_reg == CONV_LAST;

  logic [11:0] conv_val;
  logic [15:0] msb_img;
  logic [15:0] rev_img;
  logic [15:0] lsb_img;
  logic [15:0] fmt_img;
  logic [4:0]  launch_len;
  assign conv_val   = launch_ctrl_reg[SIGN_BIT] ? hold_reg ^ SIGN_FLIP : hold_reg;
  // Zero pad in the low four bits
  assign msb_img    = {conv_val, 4'h0};
  assign rev_img    = {<<{msb_img}};
  assign launch_len = launch_ctrl_reg[3:2] == LCODE_8  ? LEN_8 :
                      launch_ctrl_reg[3:2] == LCODE_16 ? LEN_16 : LEN_12;
  assign lsb_img    = launch_len == LEN_16 ? rev_img :
                      launch_len == LEN_8  ? {rev_img[7:0], 8'h00} :
                      {rev_img[11:0], 4'h0};
  assign fmt_img    = launch_ctrl_reg[ORDER_BIT] ? lsb_img : msb_img;

  // Select high always returns to idle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:  if (cs_fall) state_next = S_SETUP;
      S_SETUP: if (setup_cnt_reg == SETUP_LAST) state_next = S_SHIFT;
      S_SHIFT: if (last_fall) state_next = S_CONV;
      S_CONV:  if (conv_done) state_next = S_SHIFT;
      default: state_next = S_IDLE;
    endcase
    if (cs_n_s)
      state_next = S_IDLE;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= S_IDLE;
      cs_d_reg     <= 1'b1;
      io_clk_d_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cs_d_reg     <= cs_n_s;
      io_clk_d_reg <= io_clk_s;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      setup_cnt_reg <= 8'h00;
    else if (state_reg == S_SETUP)
      setup_cnt_reg <= setup_cnt_reg + 8'h01;
    else
      setup_cnt_reg <= 8'h00;
  end

  // Control capture on the first eight rises
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rcnt_reg <= 4'h0;
      sh_reg   <= 7'h00;
      ctrl_reg <= CTRL_RST;
    end else if (seq_start) begin
      rcnt_reg <= 4'h0;
    end else if (ctrl_take) begin
      rcnt_reg <= rcnt_reg + 4'h1;
      sh_reg   <= {sh_reg[5:0], din_s};
      if (ctrl_done)
        ctrl_reg <= {sh_reg, din_s};
    end
  end

  // Cycle length, default from control reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      len_reg  <= LEN_12;
      fcnt_reg <= 5'h00;
    end else if (seq_start) begin
      len_reg  <= LEN_12;
      fcnt_reg <= 5'h00;
    end else begin
      if (len_take)
        len_reg <= len_dec;
      if (shift_fall)
        fcnt_reg <= fcnt_inc;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      sampling_reg <= 1'b0;
    else if (last_fall || cs_n_s)
      sampling_reg <= 1'b0;
    else if (shift_fall && fcnt_inc == SAMPLE_EDGE)
      sampling_reg <= 1'b1;
  end

  // Launch on the final falling edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_reg        <= 12'h000;
      pwrdn_reg       <= 1'b0;
      launch_ctrl_reg <= CTRL_RST;
    end else if (last_fall) begin
      hold_reg        <= sel_level;
      pwrdn_reg       <= addr_sel == ADDR_PWRDN;
      launch_ctrl_reg <= ctrl_reg;
    end
  end

  // Fixed tick count, divider restarts at launch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_reg     <= 1'b0;
      div_cnt_reg  <= 8'h00;
      tick_cnt_reg <= 8'h00;
    end else if (last_fall) begin
      busy_reg     <= 1'b1;
      div_cnt_reg  <= 8'h00;
      tick_cnt_reg <= 8'h00;
    end else if (busy_reg) begin
      div_cnt_reg <= int_tick ? 8'h00 : div_cnt_reg + 8'h01;
      if (int_tick)
        tick_cnt_reg <= tick_cnt_reg + 8'h01;
      if (conv_done)
        busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      eoc_reg <= 1'b1;
    else if (last_fall)
      eoc_reg <= 1'b0;
    else if (conv_done)
      eoc_reg <= 1'b1;
  end

  // Result for the next I/O cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      img_reg <= 16'h0000;
    else if (conv_done)
      img_reg <= fmt_img;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dout_reg   <= 1'b0;
      out_sh_reg <= 16'h0000;
    end else if (cs_fall) begin
      dout_reg   <= img_reg[15];
      out_sh_reg <= {img_reg[14:0], 1'b0};
    end else if (conv_done && state_reg == S_CONV) begin
      dout_reg   <= fmt_img[15];
      out_sh_reg <= {fmt_img[14:0], 1'b0};
    end else if (shift_fall) begin
      dout_reg   <= out_sh_reg[15];
      out_sh_reg <= {out_sh_reg[14:0], 1'b0};
    end
  end

  assign data_out_oe_n = cs_n_s;
  assign data_out      = dout_reg;
  assign eoc           = eoc_reg;

  sadc_axil u_regs (
    .clock         (clock),
    .resetn        (resetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awprot  (s_axi_awprot),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arprot  (s_axi_arprot),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status_word   ({20'h00000, busy_reg, sampling_reg, pwrdn_reg, eoc_reg, ctrl_reg}),
    .result_word   ({16'h0000, img_reg}),
    .analog_reg    (analog_reg)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_HIZ_DESELECT: assert property (cs_n_s |-> data_out_oe_n && state_next == S_IDLE)
    else $error("output driven while deselected");

  AST_SETUP_WAIT: assert property ($rose(state_reg == S_SETUP) && !cs_n
    |-> (state_reg != S_SHIFT) [*2])
    else $error("edges counted during setup wait");

  AST_CTRL_CAPTURE: assert property (ctrl_done |=> ctrl_reg == $past({sh_reg, din_s}))
    else $error("control word not captured at eighth rise");

  AST_CTRL_IGNORE: assert property (shift_rise && rcnt_reg >= CTRL_BITS |=> $stable(ctrl_reg))
    else $error("serial input used after eight clocks");

  AST_SAMPLE_START: assert property (shift_fall && fcnt_reg == 5'h03 && !last_fall
    && !cs_n_s |=> sampling_reg)
    else $error("sampling did not start at fourth fall");

  AST_EOC_LAUNCH: assert property (last_fall |=> !eoc && busy_reg && state_reg != S_SHIFT)
    else $error("last fall did not launch conversion");

  AST_EOC_DONE: assert property (conv_done |=> eoc && img_reg == $past(fmt_img))
    else $error("EOC rose without result latch");

  AST_EOC_LOW_SPAN: assert property ($fell(eoc) |-> !eoc [*8])
    else $error("conversion ended too early");

  AST_FIRST_BIT_EOC: assert property (conv_done && state_reg == S_CONV
    |=> data_out == $past(fmt_img[15]))
    else $error("first bit missing at EOC rise");

  AST_SHIFT_FALL: assert property (shift_fall && !cs_fall && !conv_done
    |=> data_out == $past(out_sh_reg[15]))
    else $error("data not advanced on falling edge");

  AST_PAD16: assert property (conv_done && launch_len == LEN_16
    && !launch_ctrl_reg[ORDER_BIT] |=> img_reg[3:0] == 4'h0)
    else $error("pad bits not zero in 16-bit mode");

  COV_CYCLE_8:  cover property (last_fall && len_reg == LEN_8);
  COV_CYCLE_16: cover property (last_fall && len_reg == LEN_16);
  COV_HELD_LOW: cover property (conv_done && state_reg == S_CONV);
  COV_RESTART:  cover property (cs_fall && busy_reg);
endmodule

// ==== logic/sadc_sync.sv ====
`timescale 1ns/10ps
module sadc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,  // System clock
  input  wire logic         resetn, // Async reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output logic      [W-1:0] q       // Synchronised outputs
);
  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_chk
    $error("sadc_sync: width must be at least 1");
  end

  // Reset to the pins' idle levels, so no false edge follows reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ==== test/sadc_host.sv ====
`timescale 1ns/10ps
module sadc_host (
  input  wire logic clock,    // System clock
  input  wire logic eoc,      // End of conversion
  input  wire logic data_out, // Resolved result pin
  output logic      cs_n,     // Select, active low
  output logic      io_clk,   // Shift clock
  output logic      data_in   // Control bits
);
  initial begin
    cs_n = 1'h1;
    io_clk = 1'h0;
    data_in = 1'h0;
  end

  task automatic frame(input logic [7:0] w, input logic keep, output logic [15:0] got);
    int n;
    n = (w[3:2] == 2'h1) ? 8 : (w[3:2] == 2'h3) ? 16 : 12;
    got = 16'h0000;
    while (eoc !== 1'h1) @(posedge clock);
    if (cs_n) begin
      cs_n <= 1'h0;
      repeat (8) @(posedge clock);
    end
    repeat (4) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      // word first, then a toggling line
      data_in <= (i < 8) ? w[7-i] : ~data_in;
      repeat (8) @(posedge clock);
      io_clk <= 1'h1;
      repeat (7) @(posedge clock);
      got = {got[14:0], data_out};
      @(posedge clock);
      io_clk <= 1'h0;
    end
    repeat (5) @(posedge clock);
    data_in <= ~data_in;
    if (!keep) cs_n <= 1'h1;
  endtask
endmodule

// ==== test/test_serial_adc_io_sequencer.sv ====
`timescale 1ns/10ps
module test_serial_adc_io_sequencer import sadc_pkg::*;;
  localparam logic [11:0] LEVEL = 12'h5B3;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic cs_n, io_clk, data_in, data_out, data_out_oe_n, eoc;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] got;
  logic [7:0] ws [11] = '{8'hA0, 8'h00, 8'hEC, 8'hDD, 8'hCE, 8'h04, 8'hB4, 8'h06, 8'h04,
                         8'h03, 8'h00};
  logic [10:0] ck = 11'h5DA; // results the host trusts
  int miscompares = 0;
  int n_checks = 0;
  int k;
  wire dout_pin = data_out_oe_n ? 1'hz : data_out;

  always #5 clock = ~clock;

  sadc_seq #(.SETUP_CYC(2), .INT_DIV(2), .CONV_COUNT(8)) u_dut (.*);
  sadc_host u_host (.clock(clock), .eoc(eoc), .data_out(dout_pin), .cs_n(cs_n),
                    .io_clk(io_clk), .data_in(data_in));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic results;
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tv;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    tv = 1'h0;
    while (!tv) begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask

  function automatic logic [15:0] expv(input logic [7:0] w);
    logic [11:0] r;
    logic [15:0] im, o;
    int n;
    n = (w[3:2] == 2'h1) ? 8 : (w[3:2] == 2'h3) ? 16 : 12;
    r = (w[7:4] == ADDR_TEST_MID) ? LVL_MID : (w[7:4] == ADDR_TEST_LO) ? LVL_LO :
        (w[7:4] == ADDR_TEST_HI) ? LVL_HI : (w[7:4] >= ADDR_PWRDN) ? 12'h000 : LEVEL;
    im = {r ^ (w[0] ? SIGN_FLIP : 12'h000), 4'h0};
    o = 16'h0000;
    for (int i = 0; i < n; i++) o[n-1-i] = w[1] ? im[16-n+i] : im[15-i];
    return o;
  endfunction

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'h1;
    axr(REG_STATUS, rd, rr);
    chk({23'h0, rd[8:0]}, 32'h100);
    axw(REG_ANALOG, {20'h0, LEVEL}, rr);
    chk({30'h0, rr}, {30'h0, RESP_OKAY});
    axr(REG_ANALOG, rd, rr);
    chk(rd, {20'h0, LEVEL});
    axw(REG_RESULT, 32'h0, rr);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    axr(4'hC, rd, rr);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h0);
    for (int i = 0; i < 11; i++) begin
      u_host.frame(ws[i], i % 3 == 2, got);
      chk(32'(eoc), 32'h0);
      k = 0;
      while (eoc !== 1'h1 && k < 40) begin
        @(posedge clock);
        k++;
      end
      chk(32'(k >= 13 && k <= 16), 32'h1);
      chk(32'(data_out_oe_n), 32'(i % 3 != 2));
      axr(REG_STATUS, rd, rr);
      chk({24'h0, rd[7:0]}, {24'h0, ws[i]});
      if (ck[i]) chk({16'h0, got}, {16'h0, expv(ws[i-1])});
    end
    axr(REG_RESULT, rd, rr);
    chk(rd, {16'h0, LEVEL, 4'h0});
    results;
  end

  initial begin
    #200000;
    miscompares++;
    results;
  end
endmodule
